/* File: include/sdl_pkg.sv */
package sdl_pkg;

  // ---------------------------------------------------------------
  // serial word layout
  // ---------------------------------------------------------------
  localparam logic [4:0] WORD_LAST_BIT  = 5'h0F;   // count value at the sixteenth captured bit
  localparam int unsigned SPEED_POS     = 14;
  localparam int unsigned PWRDN_POS     = 13;
  localparam int unsigned CODE_MSB      = 11;
  localparam int unsigned CODE_LSB      = 4;

  // ---------------------------------------------------------------
  // link timing
  // ---------------------------------------------------------------
  localparam int unsigned REF_CLK_NS        = 25;   // ref_clk period
  localparam int unsigned SHIFT_CLK_MAX_MHZ = 20;   // fastest shift clock the host may use
  localparam int unsigned SYNC_STAGES       = 2;    // flops before any logic reads a pin

  // ---------------------------------------------------------------
  // apb register map
  // ---------------------------------------------------------------
  localparam int unsigned APB_AW        = 12;
  localparam logic [11:0] LATCH_OFS     = 12'h000;  // latched code, speed, power-down
  localparam logic [11:0] CTRL_OFS      = 12'h004;  // port enable, forced power-down
  localparam logic [11:0] STATUS_OFS    = 12'h008;  // phase, bit count, word counters
  localparam logic [11:0] SHIFT_OFS     = 12'h00C;  // live shift register

  localparam int unsigned CTRL_PORT_EN_POS  = 0;
  localparam int unsigned CTRL_FORCE_PD_POS = 1;
  localparam logic [1:0]  CTRL_RESET        = 2'h1; // port enabled, no forced power-down

  localparam logic [15:0] SHIFT_RESET   = 16'h0000;
  localparam logic [7:0]  CODE_RESET    = 8'h00;
  localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,   // waiting for frame_sync to fall
    PH_SHIFT = 2'b01,   // capturing bits
    PH_FULL  = 2'b10    // sixteen bits held, waiting for the next rising shift clock
  } sdl_phase_e;

  // serial pins as one bundle
  typedef struct packed {
    logic devSelN;
    logic frameSync;
    logic shiftClk;
    logic serialData;
  } sdl_pins_s;

  // apb request from the master
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0]       pwdata;
  } sdl_apb_req_s;

  // latched values for the analog section
  typedef struct packed {
    logic [7:0] dacCode;
    logic       speedSelect;
    logic       powerDownBit;
    logic       ampEnable;
  } sdl_latch_s;

endpackage : sdl_pkg

/* File: src/sdl_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module sdl_pin_sync (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire sdl_pkg::sdl_pins_s pinsIn,
  output var  sdl_pkg::sdl_pins_s pinsNow,
  output var  sdl_pkg::sdl_pins_s pinsPrev
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    sdl_pkg::sdl_pins_s meta;   // first stage, read only by the second
    sdl_pkg::sdl_pins_s now;
    sdl_pkg::sdl_pins_s prev;   // one sample older, for edge finding
  } sdl_sync_s;

  localparam sdl_pkg::sdl_pins_s PINS_IDLE = 4'hE; // deselected, sync high, clock high

  sdl_sync_s s_r;
  sdl_sync_s s_nxt;

  // shift the samples along
  always_comb begin
    s_nxt      = s_r;
    s_nxt.meta = pinsIn;
    s_nxt.now  = s_r.meta;
    s_nxt.prev = s_r.now;
  end

  // register with synchronous reset to idle pin levels
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= {PINS_IDLE, PINS_IDLE, PINS_IDLE};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pinsNow  = s_r.now;
  assign pinsPrev = s_r.prev;

endmodule : sdl_pin_sync

`default_nettype wire

/* File: src/sdl_word_loader.sv */
// Overview of operation
// - power-up clears shift register and dac latch to all zeros.
// - serial input accepted only while active-low device select is low.
// - frame_sync falling starts a word; bits taken on falling shift clock, msb first.
// - after sixteen bits or early frame_sync rise, shift register moves to latch.
// - full word latches on sixteenth rising shift clock edge, no host action.
// - bits 15..12 control, 11..0 value; 15 and 12 ignored; 11..4 code.
// - bit 14 picks speed: one fast, zero slow.
// - bit 13 picks power: one power-down, zero normal.
// - latched power-down disables all amplifiers until a cleared word latches.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module sdl_word_loader (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // serial pins
  input  wire logic              devSelN,
  input  wire logic              frameSync,
  input  wire logic              shiftClk,
  input  wire logic              serialData,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic              pready,
  output var  logic [31:0]       prdata,
  output var  logic              pslverr,
  // analog section
  output var  logic [7:0]        dacCode,
  output var  logic              speedSelect,
  output var  logic              powerDownBit,
  output var  logic              ampEnable,
  output var  logic              latchPulse
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    sdl_pkg::sdl_phase_e phase;
    logic [15:0]         shiftReg;
    logic [4:0]          bitCount;
    sdl_pkg::sdl_latch_s latch;
    logic                latchPulse;
    logic                portEnable;
    logic                forcePd;
    logic [7:0]          wordCount;
    logic [7:0]          abortCount;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
  } sdl_core_s;

  sdl_core_s          s_r;
  sdl_core_s          s_nxt;
  sdl_pkg::sdl_pins_s pinsIn;
  sdl_pkg::sdl_pins_s pinsNow;
  sdl_pkg::sdl_pins_s pinsPrev;
  sdl_pkg::sdl_apb_req_s apbReq;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // exact word address match, low two bits must be zero
  function automatic logic addrHit(input logic [11:0] addr, input logic [11:0] ofs);
    addrHit = (addr == ofs);
  endfunction : addrHit

  // a fresh latch image from a shifted word; bits 15 and 12 and 3..0 are dropped
  function automatic sdl_pkg::sdl_latch_s decodeWord(input logic [15:0] word, input logic forcePd);
    sdl_pkg::sdl_latch_s l;
    l.dacCode      = word[sdl_pkg::CODE_MSB:sdl_pkg::CODE_LSB];
    l.speedSelect  = word[sdl_pkg::SPEED_POS];
    l.powerDownBit = word[sdl_pkg::PWRDN_POS];
    l.ampEnable    = ~(word[sdl_pkg::PWRDN_POS] | forcePd);
    decodeWord = l;
  endfunction : decodeWord

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  assign pinsIn = '{devSelN: devSelN, frameSync: frameSync, shiftClk: shiftClk, serialData: serialData};

  sdl_pin_sync u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .pinsIn   (pinsIn),
    .pinsNow  (pinsNow),
    .pinsPrev (pinsPrev)
  );

  assign apbReq = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic selected;
  logic fsFall;
  logic fsRise;
  logic clkFall;
  logic clkRise;
  logic doLatch;

  // edges on the synchronised pins
  always_comb begin
    selected = ~pinsNow.devSelN & s_r.portEnable;
    fsFall   = pinsPrev.frameSync & ~pinsNow.frameSync;
    fsRise   = ~pinsPrev.frameSync & pinsNow.frameSync;
    clkFall  = pinsPrev.shiftClk & ~pinsNow.shiftClk;
    clkRise  = ~pinsPrev.shiftClk & pinsNow.shiftClk;
  end

  always_comb begin
    s_nxt            = s_r;
    s_nxt.latchPulse = 1'b0;
    s_nxt.pready     = 1'b0;
    s_nxt.pslverr    = 1'b0;
    doLatch          = 1'b0;

    // serial word framing
    case (s_r.phase)
      sdl_pkg::PH_IDLE: begin
        if (selected && fsFall) begin
          s_nxt.phase    = sdl_pkg::PH_SHIFT;
          s_nxt.bitCount = 5'h00;
        end
      end
      sdl_pkg::PH_SHIFT: begin
        if (!selected) begin
          s_nxt.phase      = sdl_pkg::PH_IDLE;
          s_nxt.abortCount = s_r.abortCount + 8'h01;
        end else if (fsRise) begin
          doLatch      = 1'b1;
          s_nxt.phase  = sdl_pkg::PH_IDLE;
        end else if (fsFall) begin
          s_nxt.bitCount = 5'h00;                                      // restart the word
        end else if (clkFall) begin
          s_nxt.shiftReg = {s_r.shiftReg[14:0], pinsPrev.serialData};  // msb first
          s_nxt.bitCount = s_r.bitCount + 5'h01;
          if (s_r.bitCount == sdl_pkg::WORD_LAST_BIT) begin
            s_nxt.phase = sdl_pkg::PH_FULL;
          end
        end
      end
      sdl_pkg::PH_FULL: begin
        if (!selected) begin
          s_nxt.phase      = sdl_pkg::PH_IDLE;
          s_nxt.abortCount = s_r.abortCount + 8'h01;
        end else if (clkRise || fsRise) begin
          doLatch     = 1'b1;
          s_nxt.phase = sdl_pkg::PH_IDLE;
        end
      end
      default: begin
        s_nxt.phase = sdl_pkg::PH_IDLE;
      end
    endcase

    // latch update drives the analog section
    if (doLatch) begin
      s_nxt.latch      = decodeWord(s_r.shiftReg, s_r.forcePd);
      s_nxt.latchPulse = 1'b1;
      s_nxt.wordCount  = s_r.wordCount + 8'h01;
    end

    // apb access phase: answer one cycle after penable rises
    if (apbReq.psel && apbReq.penable && !s_r.pready) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = sdl_pkg::RDATA_ZERO;
      if (addrHit(apbReq.paddr, sdl_pkg::LATCH_OFS)) begin
        s_nxt.prdata[7:0] = s_r.latch.dacCode;
        s_nxt.prdata[8]   = s_r.latch.speedSelect;
        s_nxt.prdata[9]   = s_r.latch.powerDownBit;
        s_nxt.prdata[10]  = s_r.latch.ampEnable;
      end else if (addrHit(apbReq.paddr, sdl_pkg::CTRL_OFS)) begin
        s_nxt.prdata[sdl_pkg::CTRL_PORT_EN_POS]  = s_r.portEnable;
        s_nxt.prdata[sdl_pkg::CTRL_FORCE_PD_POS] = s_r.forcePd;
      end else if (addrHit(apbReq.paddr, sdl_pkg::STATUS_OFS)) begin
        s_nxt.prdata[1:0]   = s_r.phase;
        s_nxt.prdata[6:2]   = s_r.bitCount;
        s_nxt.prdata[15:8]  = s_r.wordCount;
        s_nxt.prdata[23:16] = s_r.abortCount;
        s_nxt.prdata[24]    = selected;
      end else if (addrHit(apbReq.paddr, sdl_pkg::SHIFT_OFS)) begin
        s_nxt.prdata[15:0] = s_r.shiftReg;
      end else begin
        s_nxt.pslverr = 1'b1;                                          // unmapped word
      end
    end

    // write takes effect on the edge that samples pready high
    if (apbReq.psel && apbReq.penable && s_r.pready && apbReq.pwrite
        && addrHit(apbReq.paddr, sdl_pkg::CTRL_OFS)) begin
      s_nxt.portEnable = apbReq.pwdata[sdl_pkg::CTRL_PORT_EN_POS];
      s_nxt.forcePd    = apbReq.pwdata[sdl_pkg::CTRL_FORCE_PD_POS];
    end

    // amplifiers follow latched power-down and the forced override
    s_nxt.latch.ampEnable = ~(s_nxt.latch.powerDownBit | s_nxt.forcePd);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r.phase              <= sdl_pkg::PH_IDLE;
      s_r.shiftReg           <= sdl_pkg::SHIFT_RESET;
      s_r.bitCount           <= 5'h00;
      s_r.latch.dacCode      <= sdl_pkg::CODE_RESET;
      s_r.latch.speedSelect  <= 1'b0;
      s_r.latch.powerDownBit <= 1'b0;
      s_r.latch.ampEnable    <= 1'b1;
      s_r.latchPulse         <= 1'b0;
      s_r.portEnable         <= sdl_pkg::CTRL_RESET[sdl_pkg::CTRL_PORT_EN_POS];
      s_r.forcePd            <= sdl_pkg::CTRL_RESET[sdl_pkg::CTRL_FORCE_PD_POS];
      s_r.wordCount          <= 8'h00;
      s_r.abortCount         <= 8'h00;
      s_r.pready             <= 1'b0;
      s_r.pslverr            <= 1'b0;
      s_r.prdata             <= sdl_pkg::RDATA_ZERO;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs, straight from flops
  // ---------------------------------------------------------------
  assign pready       = s_r.pready;
  assign prdata       = s_r.prdata;
  assign pslverr      = s_r.pslverr;
  assign dacCode      = s_r.latch.dacCode;
  assign speedSelect  = s_r.latch.speedSelect;
  assign powerDownBit = s_r.latch.powerDownBit;
  assign ampEnable    = s_r.latch.ampEnable;
  assign latchPulse   = s_r.latchPulse;

endmodule : sdl_word_loader

`default_nettype wire

/* File: sim/sdl_word_loader_props.sv */
`timescale 1ns/1ps
`default_nettype none

module sdl_word_loader_props (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        devSelN,
  input wire logic        frameSync,
  input wire logic        shiftClk,
  input wire logic        serialData,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [7:0]  dacCode,
  input wire logic        speedSelect,
  input wire logic        powerDownBit,
  input wire logic        ampEnable,
  input wire logic        latchPulse
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // latch behaviour
  // ---------------------------------------------------------------
  a_reset_clear: assert property ($fell(rst) |-> dacCode == 8'h00 && !speedSelect && !powerDownBit)
    else $error("latch not cleared by reset");
  a_desel_quiet: assert property (devSelN [*8] |-> !latchPulse)
    else $error("latch while deselected");
  a_sync_high_quiet: assert property (frameSync [*8] |-> !latchPulse)
    else $error("latch without a frame");
  a_pulse_single: assert property (latchPulse |=> !latchPulse)
    else $error("latch pulse too long");
  // pulse must follow a rising shift clock or rising frame sync by a few cycles
  a_latch_cause: assert property (latchPulse |-> (!$past(shiftClk, 6) && $past(shiftClk, 2))
    || (!$past(frameSync, 6) && $past(frameSync, 2))) else $error("latch without rising edge");
  a_latch_stable: assert property ($changed({dacCode, speedSelect, powerDownBit})
    |-> latchPulse || $past(latchPulse)) else $error("outputs moved without latch");
  a_pd_amp_off: assert property (powerDownBit && $past(powerDownBit) |-> !ampEnable)
    else $error("amplifiers on in power-down");

  // ---------------------------------------------------------------
  // register bus answer
  // ---------------------------------------------------------------
  a_pready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait state");
  a_slverr_pairs: assert property (pslverr |-> pready)
    else $error("error without ready");

  c_latch_pd: cover property (latchPulse ##1 powerDownBit);
  c_latch_fast: cover property (latchPulse ##1 speedSelect);
  c_bus_error: cover property (pslverr);
endmodule : sdl_word_loader_props

bind sdl_word_loader sdl_word_loader_props i_props (.*);

`default_nettype wire

/* File: sim/sdl_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module sdl_host_model (
  input  wire logic ref_clk,
  output var  logic devSelN,
  output var  logic frameSync,
  output var  logic shiftClk,
  output var  logic serialData
);
  // idle: selected, sync and clock high
  initial begin
    devSelN    = 1'b0;
    frameSync  = 1'b1;
    shiftClk   = 1'b1;
    serialData = 1'b0;
  end

  // whole ref_clk cycles; pins move only just after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  // one frame of n bits; shift clock period is eight ref_clk cycles, 200 ns
  task automatic send(input logic [15:0] w, input int n, input bit sel, input bit by, input bit ab);
    tick(1);
    devSelN <= !sel; // only the target is selected
    tick(6);
    frameSync <= 1'b0; // sync falls before data
    tick(4);
    for (int i = 0; i < n; i++) begin
      serialData <= w[15-i]; // msb first
      tick(4);
      shiftClk <= 1'b0; // 200 ns period, well under the limit
      tick(4);
      shiftClk <= 1'b1;
      if (by && i == 7)
        tick(24); // gap between two byte writes
      if (ab && i == 7)
        devSelN <= 1'b1;
    end
    serialData <= !serialData; // released line shows the inverse
    tick(12);
    frameSync <= 1'b1;
    tick(8);
    devSelN <= 1'b0; // select held low between frames
  endtask : send
endmodule : sdl_host_model

`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
  typedef struct {
    logic [15:0] w;
    int          n;
    bit          sel;
    bit          by;
    logic [7:0]  code;
    logic        speed_select;
    logic        pd;
    int          lat;
  } sdl_row_s;

  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, speedSelect, powerDownBit, ampEnable, latchPulse;
  logic        devSelN, frameSync, shiftClk, serialData;
  logic [7:0]  dacCode;
  int          fail_count = 0, n_tests = 0, nLatch = 0, base;
  wire  [31:0] outsNow = {21'h00_0000, ampEnable, powerDownBit, speedSelect, dacCode};
  // word, bits, selected, byte-wise, code, speed, power-down, latches
  sdl_row_s    rows [6] = '{'{16'h4AB0, 16, 1, 0, 8'hAB, 1, 0, 1}, '{16'h2FF0, 16, 1, 0, 8'hFF, 0, 1, 1},
                            '{16'h9000, 16, 1, 0, 8'h00, 0, 0, 1}, '{16'h7FF0, 16, 0, 0, 8'h00, 0, 0, 0},
                            '{16'h4A50, 12, 1, 0, 8'h4A, 0, 0, 1}, '{16'h6120, 16, 1, 1, 8'h12, 1, 1, 1}};

  sdl_host_model  i_host (.*);
  sdl_word_loader i_dut (.*);

  // clock and latch counter
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (latchPulse === 1'b1) nLatch <= nLatch + 1;

  function automatic logic [31:0] ex(input logic [7:0] c, input logic s, input logic p, input logic a);
    return {21'h00_0000, a, p, s, c};
  endfunction : ex

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer; waits for pready, only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  task automatic word(input logic [15:0] w, input int n, input bit sel, input bit by, input bit ab, input int lat);
    base = nLatch;
    i_host.send(w, n, sel, by, ab);
    repeat (10) @(posedge ref_clk);
    chk(32'(nLatch - base), 32'(lat));
  endtask : word

  task automatic final_report;
    if (fail_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(outsNow, ex(8'h00, 1'b0, 1'b0, 1'b1));
    for (int i = 0; i < 6; i++) begin
      word(rows[i].w, rows[i].n, rows[i].sel, rows[i].by, 0, rows[i].lat);
      chk(outsNow, ex(rows[i].code, rows[i].speed_select, rows[i].pd, !rows[i].pd));
    end
    word(16'h4330, 16, 1, 0, 1, 0);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(rd, ex(8'h12, 1'b1, 1'b1, 1'b0));
    apb(1'b1, 12'h004, 32'h0000_0003);
    word(16'h4550, 16, 1, 0, 0, 1);
    chk(outsNow, ex(8'h55, 1'b1, 1'b0, 1'b0));
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    apb(1'b1, 12'h004, 32'h0000_0000);
    word(16'h4660, 16, 1, 0, 0, 0);
    apb(1'b1, 12'h004, 32'h0000_0001);
    word(16'h0000, 16, 1, 0, 0, 1);
    chk(outsNow, ex(8'h00, 1'b0, 1'b0, 1'b1));
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    word(16'h6FF0, 16, 1, 0, 0, 1);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk(rd, 32'h0000_6FF0);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(rd, 32'h0101_0840);
    rst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(outsNow, ex(8'h00, 1'b0, 1'b0, 1'b1));
    final_report();
  end

  // watchdog: about eight times the expected run of eleven frames
  initial begin
    #400_000;
    fail_count++;
    final_report();
  end
endmodule : tb

`default_nettype wire
